// file: design/fp_stack_defs.svh
`ifndef FP_STACK_DEFS_SVH
`define FP_STACK_DEFS_SVH

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define FPS_DATA_W 80
`define FPS_REGS 8
`define FPS_PTR_W 3
`define FPS_TOP_RESET 3'h0
`define FPS_TOP_LSB 11
`define FPS_TOP_MSB 13
`define FPS_STATUS_W 16
`define FPS_CTRL_RESET 16'h037F
`define FPS_TAG_RESET 16'hFFFF
`define FPS_PKD_W 64
`define FPS_PKD_EXP 16'hFFFF
`define FPS_EXT_W 64

// ****************************************************************
// Store format codes
// ****************************************************************
`define FPS_FMT_W 2
`define FPS_FMT_EXT 2'h0
`define FPS_FMT_SHORT 2'h1
`define FPS_FMT_INT 2'h2
`define FPS_FMT_BCD 2'h3

`endif

// file: design/fp_stack_pkg.sv
package fp_stack_pkg;
  // Operations the decoder may issue to the register stack
  typedef enum logic [3:0] {
    OP_NONE,
    OP_PUSH_LOAD,
    OP_LOAD_NOPUSH,
    OP_POP_STORE,
    OP_STORE_NOPOP,
    OP_EXCHANGE,
    OP_WRITE_REL,
    OP_PACKED_WRITE,
    OP_CALL_RET,
    OP_CLEAR_EXC
  } op_t;
endpackage

// file: design/fp_format_conv.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_stack_defs.svh"

// ****************************************************************
// Memory value to extended format conversion
// ****************************************************************
// Combinational: values already extended pass unchanged; other formats
// are widened by the memory path upstream into the 64-bit significand
// carried here, and this module forms the 80-bit extended word.
module fp_format_conv (
  // Source value
  input wire logic [`FPS_DATA_W-1:0] src_val,
  input wire logic [`FPS_FMT_W-1:0] src_fmt,
  // Result
  output logic [`FPS_DATA_W-1:0] ext_val
);
  logic [`FPS_EXT_W-1:0] mag;

  // Non-extended inputs: sign in bit 79, magnitude in low bits
  always_comb begin
    mag = src_val[`FPS_EXT_W-1:0];
    if (src_fmt == `FPS_FMT_EXT) begin
      ext_val = src_val;
    end else if (mag == '0) begin
      ext_val = {src_val[`FPS_DATA_W-1], {(`FPS_DATA_W-1){1'b0}}};
    end else begin
      // Integer-style magnitude scaled to an exponent of 63
      ext_val = {src_val[`FPS_DATA_W-1], 15'h403E, mag};
    end
  end
endmodule
`default_nettype wire

// file: design/fp_register_stack.sv
// Overview of operation
// - Eight registers, each eighty bits wide
// - Loads convert to extended format when needed
// - Stores leave extended, with the asked format passed along
// - All accesses but packed-integer writes resolve relative to stack top
// - Stack-top pointer kept in status word
// - Push load decrements pointer, then writes top
// - Pop store reads top, then increments pointer
// - Load and store variants without pointer change
// - Push at pointer zero wraps to seven
// - Overflow flagged when push hits unsaved register
// - Top operand and indexed operands zero to seven
// - Physical register equals pointer plus index
// - Exchange swaps top with another register
// - Call and return leave stack unchanged
// - Packed-integer writes alias onto data registers
// - State independent of other execution units
// - Holds status, control, tag, pointers, opcode
// - Pointer sits in status bits eleven to thirteen
`timescale 1ns/1ps
`default_nettype none
`include "fp_stack_defs.svh"

module fp_register_stack #(
  parameter int DATA_W = `FPS_DATA_W,
  parameter int REGS = `FPS_REGS
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Operation request
  input wire logic op_valid,
  input wire fp_stack_pkg::op_t op_code,
  input wire logic [`FPS_PTR_W-1:0] op_index,
  // Load data and format
  input wire logic [DATA_W-1:0] load_data,
  input wire logic [`FPS_FMT_W-1:0] load_fmt,
  // Store format request
  input wire logic [`FPS_FMT_W-1:0] store_fmt,
  // Packed-integer alias write
  input wire logic [`FPS_PKD_W-1:0] packed_data,
  // Instruction bookkeeping
  input wire logic [47:0] instr_ptr,
  input wire logic [47:0] operand_ptr,
  input wire logic [10:0] opcode,
  input wire logic [15:0] ctrl_wdata,
  input wire logic ctrl_we,
  // Store result
  output logic [DATA_W-1:0] store_data,
  output logic [`FPS_FMT_W-1:0] store_data_fmt,
  output logic store_valid,
  // Operand read port
  output logic [DATA_W-1:0] stack_top_operand,
  output logic [DATA_W-1:0] stack_relative_operand,
  // Status and bookkeeping
  output logic [`FPS_STATUS_W-1:0] status_word,
  output logic [15:0] control_word,
  output logic [15:0] tag_word,
  output logic [47:0] last_instr_ptr,
  output logic [47:0] last_operand_ptr,
  output logic [10:0] last_opcode,
  output logic stack_overflow,
  output logic stack_underflow
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [DATA_W-1:0] data_reg [REGS];
  logic [REGS-1:0] valid_reg;
  logic [`FPS_PTR_W-1:0] top_reg;
  logic overflow_reg;
  logic underflow_reg;
  logic [15:0] control_reg;
  logic [47:0] ip_reg;
  logic [47:0] dp_reg;
  logic [10:0] opc_reg;
  logic [DATA_W-1:0] store_reg;
  logic [`FPS_FMT_W-1:0] store_fmt_reg;
  logic store_valid_reg;

  // ****************************************************************
  // Addressing
  // ****************************************************************
  logic [`FPS_PTR_W-1:0] top_dec;
  logic [`FPS_PTR_W-1:0] top_inc;
  logic [`FPS_PTR_W-1:0] rel_phys;
  logic [DATA_W-1:0] load_ext;
  logic [DATA_W-1:0] packed_ext;
  logic fire;
  logic push_hit;
  logic pop_empty;

  // Three-bit sums wrap on their own
  assign top_dec = top_reg - 3'h1;
  assign top_inc = top_reg + 3'h1;
  assign rel_phys = top_reg + op_index;
  assign fire = clk_en && op_valid;

  // Only a push onto a still-valid register loses data
  assign push_hit = valid_reg[top_dec];
  assign pop_empty = !valid_reg[top_reg];

  // Packed writes set exponent to all ones as the alias rule does
  assign packed_ext = {`FPS_PKD_EXP, packed_data};

  // Load conversion
  fp_format_conv u_conv (
    .src_val(load_data),
    .src_fmt(load_fmt),
    .ext_val(load_ext)
  );

  // Operand outputs read through the pointer, never by number
  assign stack_top_operand = data_reg[top_reg];
  assign stack_relative_operand = data_reg[rel_phys];

  // ****************************************************************
  // Data registers
  // ****************************************************************
  // Writes never collide: one operation per cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < REGS; i++) begin
        data_reg[i] <= '0;
      end
    end else if (fire) begin
      case (op_code)
        fp_stack_pkg::OP_PUSH_LOAD: begin
          data_reg[top_dec] <= load_ext;
        end
        fp_stack_pkg::OP_LOAD_NOPUSH,
        fp_stack_pkg::OP_WRITE_REL: begin
          data_reg[rel_phys] <= load_ext;
        end
        fp_stack_pkg::OP_EXCHANGE: begin
          data_reg[top_reg] <= data_reg[rel_phys];
          data_reg[rel_phys] <= data_reg[top_reg];
        end
        fp_stack_pkg::OP_PACKED_WRITE: begin
          // Index picks an absolute alias slot, not stack relative
          data_reg[op_index] <= packed_ext;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Valid bits behind the tag word
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      valid_reg <= '0;
    end else if (fire) begin
      case (op_code)
        fp_stack_pkg::OP_PUSH_LOAD: begin
          valid_reg[top_dec] <= 1'b1;
        end
        fp_stack_pkg::OP_LOAD_NOPUSH,
        fp_stack_pkg::OP_WRITE_REL: begin
          valid_reg[rel_phys] <= 1'b1;
        end
        fp_stack_pkg::OP_EXCHANGE: begin
          valid_reg[top_reg] <= valid_reg[rel_phys];
          valid_reg[rel_phys] <= valid_reg[top_reg];
        end
        fp_stack_pkg::OP_POP_STORE: begin
          valid_reg[top_reg] <= 1'b0;
        end
        fp_stack_pkg::OP_PACKED_WRITE: begin
          valid_reg <= '1;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Stack-top pointer
  // ****************************************************************
  // Call and return fall through the default and hold the pointer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      top_reg <= `FPS_TOP_RESET;
    end else if (fire) begin
      case (op_code)
        fp_stack_pkg::OP_PUSH_LOAD: top_reg <= top_dec;
        fp_stack_pkg::OP_POP_STORE: top_reg <= top_inc;
        fp_stack_pkg::OP_PACKED_WRITE: top_reg <= `FPS_TOP_RESET;
        default: top_reg <= top_reg;
      endcase
    end
  end

  // ****************************************************************
  // Stack faults, sticky until cleared
  // ****************************************************************
  // A new fault in the clearing cycle wins over the clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_reg <= 1'b0;
      underflow_reg <= 1'b0;
    end else if (fire) begin
      if (op_code == fp_stack_pkg::OP_PUSH_LOAD && push_hit) begin
        overflow_reg <= 1'b1;
      end else if (op_code == fp_stack_pkg::OP_CLEAR_EXC) begin
        overflow_reg <= 1'b0;
      end
      if (op_code == fp_stack_pkg::OP_POP_STORE && pop_empty) begin
        underflow_reg <= 1'b1;
      end else if (op_code == fp_stack_pkg::OP_CLEAR_EXC) begin
        underflow_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Store path
  // ****************************************************************
  // Data leaves extended; the requested format rides alongside so the
  // memory path narrows it, which keeps the wide rounder out of here
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      store_reg <= '0;
      store_fmt_reg <= `FPS_FMT_EXT;
      store_valid_reg <= 1'b0;
    end else if (clk_en) begin
      store_valid_reg <= 1'b0;
      if (op_valid && (op_code == fp_stack_pkg::OP_POP_STORE ||
          op_code == fp_stack_pkg::OP_STORE_NOPOP)) begin
        // A pop always leaves from the top; only the plain store is indexed
        if (op_code == fp_stack_pkg::OP_POP_STORE) begin
          store_reg <= data_reg[top_reg];
        end else begin
          store_reg <= data_reg[rel_phys];
        end
        store_fmt_reg <= store_fmt;
        store_valid_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Bookkeeping registers
  // ****************************************************************
  // Only this unit's own inputs reach these; nothing is shared
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_reg <= `FPS_CTRL_RESET;
      ip_reg <= '0;
      dp_reg <= '0;
      opc_reg <= '0;
    end else if (clk_en) begin
      if (ctrl_we) begin
        control_reg <= ctrl_wdata;
      end
      if (op_valid && op_code != fp_stack_pkg::OP_CALL_RET) begin
        ip_reg <= instr_ptr;
        dp_reg <= operand_ptr;
        opc_reg <= opcode;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Tag: 00 valid, 11 empty, per register
  always_comb begin
    tag_word = `FPS_TAG_RESET;
    for (int i = 0; i < REGS; i++) begin
      if (valid_reg[i]) begin
        tag_word[2*i +: 2] = 2'b00;
      end
    end
  end

  // Status: stack fault in bit 6, invalid in bit 0, C1 marks overflow
  always_comb begin
    status_word = '0;
    status_word[`FPS_TOP_MSB:`FPS_TOP_LSB] = top_reg;
    status_word[6] = overflow_reg | underflow_reg;
    status_word[0] = overflow_reg | underflow_reg;
    status_word[9] = overflow_reg;
  end

  assign control_word = control_reg;
  assign last_instr_ptr = ip_reg;
  assign last_operand_ptr = dp_reg;
  assign last_opcode = opc_reg;
  assign stack_overflow = overflow_reg;
  assign stack_underflow = underflow_reg;
  assign store_data = store_reg;
  assign store_data_fmt = store_fmt_reg;
  assign store_valid = store_valid_reg;

endmodule
`default_nettype wire

// file: tb/fp_register_stack_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_stack_defs.svh"
module fp_register_stack_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Requests
  input wire logic clk_en,
  input wire logic op_valid,
  input wire fp_stack_pkg::op_t op_code,
  input wire logic [`FPS_DATA_W-1:0] load_data,
  input wire logic [`FPS_FMT_W-1:0] load_fmt,
  input wire logic [`FPS_FMT_W-1:0] store_fmt,
  // Results
  input wire logic [`FPS_DATA_W-1:0] store_data,
  input wire logic [`FPS_FMT_W-1:0] store_data_fmt,
  input wire logic store_valid,
  input wire logic [`FPS_DATA_W-1:0] stack_top_operand,
  input wire logic [`FPS_STATUS_W-1:0] status_word,
  input wire logic [15:0] tag_word,
  input wire logic stack_overflow
);
  // ********
  // Request decode
  // ********
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic take;
  logic [2:0] top;
  logic [2:0] below;
  // Slot a push would land on, so overflow can be judged before the edge
  assign take = op_valid && clk_en;
  assign top = status_word[`FPS_TOP_MSB:`FPS_TOP_LSB];
  assign below = top - 3'h1;
  sequence push_s;
    take && op_code == fp_stack_pkg::OP_PUSH_LOAD;
  endsequence
  sequence pop_s;
    take && op_code == fp_stack_pkg::OP_POP_STORE;
  endsequence
  // ********
  // Stack pointer and data
  // ********
  a_push_dec_top: assert property (push_s |=> top == $past(below))
    else $error("push did not lower the stack top");
  a_pop_inc_top: assert property (pop_s |=> top == $past(top) + 3'h1)
    else $error("pop did not raise the stack top");
  a_pop_store_top: assert property (pop_s |=> store_valid &&
    store_data == $past(stack_top_operand))
    else $error("pop did not store the old top");
  a_push_ext_data: assert property (
    (push_s ##0 load_fmt == `FPS_FMT_EXT) |=> stack_top_operand == $past(load_data))
    else $error("extended load was altered");
  a_nopush_top_kept: assert property (take &&
    op_code inside {fp_stack_pkg::OP_LOAD_NOPUSH, fp_stack_pkg::OP_STORE_NOPOP,
    fp_stack_pkg::OP_EXCHANGE} |=> $stable(top))
    else $error("non-stacking access moved the top");
  a_call_keeps_top: assert property (
    take && op_code == fp_stack_pkg::OP_CALL_RET |=> $stable(stack_top_operand)
    && $stable(status_word))
    else $error("call or return changed the stack");
  a_push_overflow: assert property (
    (push_s ##0 tag_word[{below, 1'b0} +: 2] == 2'h0) |=> stack_overflow)
    else $error("push onto a live slot not flagged");
  a_store_fmt_echo: assert property (
    $rose(store_valid) |-> store_data_fmt == $past(store_fmt))
    else $error("store format not carried");
endmodule
bind fp_register_stack fp_register_stack_chk u_chk (
  .mclk, .reset_n, .clk_en, .op_valid, .op_code, .load_data, .load_fmt,
  .store_fmt, .store_data, .store_data_fmt, .store_valid,
  .stack_top_operand, .status_word, .tag_word, .stack_overflow
);
`default_nettype wire

// file: tb/store_sink.sv
`timescale 1ns/1ps
`default_nettype none
module store_sink (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Store stream
  input wire logic store_valid,
  input wire logic [79:0] store_data,
  // What memory last received
  output logic [79:0] last_store,
  output logic [7:0] store_cnt
);
  // Memory takes the word only on the pulse edge and holds it until the next store
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      last_store <= 80'h0;
      store_cnt <= 8'h0;
    end else if (store_valid) begin
      last_store <= store_data;
      store_cnt <= store_cnt + 8'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb/fp_register_stack_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_stack_defs.svh"
module fp_register_stack_bench;
  // ********
  // Signals
  // ********
  typedef struct {
    fp_stack_pkg::op_t op;
    logic [2:0] idx;
    logic [7:0] d;
    logic [2:0] top;
    logic [7:0] rel;
    logic [7:0] st;
  } row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic op_valid = 1'b0;
  fp_stack_pkg::op_t op_code = fp_stack_pkg::OP_NONE;
  logic [2:0] op_index = 3'h0;
  logic [79:0] load_data = 80'h0;
  logic [1:0] load_fmt = 2'h0;
  logic [1:0] store_fmt = 2'h3;
  logic [63:0] packed_data = 64'h0;
  logic [79:0] store_data, stack_top_operand, stack_relative_operand;
  logic [1:0] store_data_fmt;
  logic store_valid, stack_overflow, stack_underflow;
  logic [15:0] status_word, tag_word;
  logic [79:0] last_store, top_w;
  logic [7:0] store_cnt;
  int fail_count = 0;
  int checks = 0;
  row_t rows [8];
  assign top_w = {77'h0, status_word[13:11]};
  always #2 mclk = ~mclk;
  fp_register_stack u_fp_register_stack (
    .mclk, .reset_n, .clk_en, .op_valid, .op_code, .op_index,
    .load_data, .load_fmt, .store_fmt, .packed_data,
    .instr_ptr(48'h0), .operand_ptr(48'h0), .opcode(11'h0),
    .ctrl_wdata(16'h0), .ctrl_we(1'b0), .store_data, .store_data_fmt,
    .store_valid, .stack_top_operand, .stack_relative_operand,
    .status_word, .control_word(), .tag_word, .last_instr_ptr(),
    .last_operand_ptr(), .last_opcode(), .stack_overflow,
    .stack_underflow
  );
  store_sink u_store_sink (.mclk, .reset_n, .store_valid, .store_data,
    .last_store, .store_cnt);
  // ********
  // Helpers
  // ********
  function automatic logic [79:0] ext(input logic [7:0] d);
    return {16'h3FFF, d, 56'h0};
  endfunction
  task automatic chk_val(input string name, input logic [79:0] exp,
      input logic [79:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_flag(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Three cycles per op so the sink has taken any store before checks
  task automatic do_op(input fp_stack_pkg::op_t op, input logic [2:0] idx,
      input logic [1:0] fmt, input logic [79:0] din);
    @(negedge mclk);
    op_valid = 1'b1;
    op_code = op;
    op_index = idx;
    load_fmt = fmt;
    load_data = din;
    @(negedge mclk);
    op_valid = 1'b0;
    @(negedge mclk);
  endtask
  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    rows = '{
      '{fp_stack_pkg::OP_PUSH_LOAD,3'h0,8'hA1,3'h7,8'hA1,8'h00},
      '{fp_stack_pkg::OP_PUSH_LOAD,3'h1,8'hB2,3'h6,8'hA1,8'h00},
      '{fp_stack_pkg::OP_PUSH_LOAD,3'h2,8'hC3,3'h5,8'hA1,8'h00},
      '{fp_stack_pkg::OP_EXCHANGE,3'h2,8'h00,3'h5,8'hC3,8'h00},
      '{fp_stack_pkg::OP_CALL_RET,3'h0,8'h00,3'h5,8'hA1,8'h00},
      '{fp_stack_pkg::OP_LOAD_NOPUSH,3'h0,8'hD4,3'h5,8'hD4,8'h00},
      '{fp_stack_pkg::OP_POP_STORE,3'h0,8'h00,3'h6,8'hB2,8'hD4},
      '{fp_stack_pkg::OP_STORE_NOPOP,3'h0,8'h00,3'h6,8'hB2,8'hB2}};
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    chk_val("top", 80'h0, top_w);
    chk_val("tags", {64'h0, `FPS_TAG_RESET}, {64'h0, tag_word});
    foreach (rows[i]) begin
      do_op(rows[i].op, rows[i].idx, 2'h0, ext(rows[i].d));
      chk_val("top", {77'h0, rows[i].top}, top_w);
      chk_val("rel", ext(rows[i].rel), stack_relative_operand);
      if (rows[i].st != 8'h00) begin
        chk_val("store", ext(rows[i].st), last_store);
      end
    end
    chk_val("stores", 80'h2, {72'h0, store_cnt});
    // Integer load: sign, fixed exponent, raw magnitude
    do_op(fp_stack_pkg::OP_PUSH_LOAD, 3'h0, `FPS_FMT_INT, 80'h5);
    chk_val("conv", {1'b0, 15'h403E, 64'h5}, stack_top_operand);
    for (int k = 0; k < 5; k++) begin
      do_op(fp_stack_pkg::OP_PUSH_LOAD, 3'h0, 2'h0, ext(8'h10));
    end
    chk_flag("ovf", 1'b0, stack_overflow);
    chk_val("top", 80'h0, top_w);
    do_op(fp_stack_pkg::OP_PUSH_LOAD, 3'h0, 2'h0, ext(8'h20));
    chk_flag("ovf", 1'b1, stack_overflow);
    chk_val("top", 80'h7, top_w);
    do_op(fp_stack_pkg::OP_POP_STORE, 3'h0, 2'h0, 80'h0);
    chk_val("top", 80'h0, top_w);
    chk_val("store", ext(8'h20), last_store);
    packed_data = 64'h1234;
    do_op(fp_stack_pkg::OP_PACKED_WRITE, 3'h3, 2'h0, 80'h0);
    chk_val("alias", {16'hFFFF, 64'h1234}, stack_relative_operand);
    // Frozen cycle: a request with the enable low must change nothing
    clk_en = 1'b0;
    do_op(fp_stack_pkg::OP_POP_STORE, 3'h0, 2'h0, 80'h0);
    chk_val("top", 80'h0, top_w);
    clk_en = 1'b1;
    do_op(fp_stack_pkg::OP_PUSH_LOAD, 3'h0, 2'h0, ext(8'h30));
    reset_n = 1'b0;
    @(negedge mclk);
    chk_val("top", 80'h0, top_w);
    chk_val("tags", {64'h0, `FPS_TAG_RESET}, {64'h0, tag_word});
    reset_n = 1'b1;
    // Pop of an empty slot, then an indexed write, then clear the fault
    do_op(fp_stack_pkg::OP_POP_STORE, 3'h0, 2'h0, 80'h0);
    chk_flag("unf", 1'b1, stack_underflow);
    chk_val("fmt", 80'h3, {78'h0, store_data_fmt});
    do_op(fp_stack_pkg::OP_WRITE_REL, 3'h2, 2'h0, ext(8'h44));
    chk_val("wrel", ext(8'h44), stack_relative_operand);
    chk_val("top", 80'h1, top_w);
    do_op(fp_stack_pkg::OP_CLEAR_EXC, 3'h0, 2'h0, 80'h0);
    chk_flag("unf", 1'b0, stack_underflow);
    chk_flag("ovf", 1'b0, stack_overflow);
    end_sim();
  end
endmodule
`default_nettype wire
